/* File: rtl/accel_axis.sv */
// One acceleration axis: self-test force, trim, range scaling and the
// wake and free-fall compares.
// Assumes raw samples arrive on the core clock with a one-cycle strobe.
`timescale 1ns/1ps
module accel_axis #(
    parameter logic signed [accel_pkg::DATA_W-1:0] ST_FORCE = '0
) (
    input  wire logic                             clk_i,
    input  wire logic                             rst_i,
    input  wire logic                             sample_i,
    input  wire logic signed [accel_pkg::DATA_W-1:0] raw_i,
    input  wire logic [accel_pkg::GAIN_W-1:0]     gain_i,
    input  wire logic [accel_pkg::OFFS_W-1:0]     offset_i,
    input  wire logic                             selftest_enable_i,
    input  wire logic [1:0]                       fs_i,
    input  wire logic [accel_pkg::DATA_W-1:0]     wake_thr_i,
    input  wire logic [accel_pkg::DATA_W-1:0]     ff_thr_i,
    output logic signed [accel_pkg::DATA_W-1:0]   out_o,
    output logic                                  above_o,
    output logic                                  below_o
);
    import accel_pkg::*;

    logic signed [DATA_W+1:0]        sum;
    logic signed [DATA_W+GAIN_W+2:0] prod;
    logic signed [DATA_W+1:0]        trimmed;
    logic signed [DATA_W+1:0]        scaled;
    logic        [DATA_W-1:0]        mag;

    always_comb begin
        // Test force is added ahead of gain so it scales like real input
        sum = (DATA_W+2)'(raw_i);
        if (selftest_enable_i) begin
            sum = sum + (DATA_W+2)'(ST_FORCE);  // [R1] [R2]
        end
        prod    = sum * $signed({1'b0, gain_i});  // [R3]
        trimmed = (DATA_W+2)'(prod >>> GAIN_SH)
                  - (DATA_W+2)'($signed(offset_i));  // [R3]
        scaled  = trimmed >>> fs_i;  // [R2]
        mag     = scaled[DATA_W-1] ? DATA_W'(-scaled) : scaled[DATA_W-1:0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_o   <= '0;
            above_o <= 1'b0;
            below_o <= 1'b0;
        end else if (sample_i) begin
            out_o   <= scaled[DATA_W-1:0];  // [R9]
            above_o <= mag > wake_thr_i;
            below_o <= mag < ff_thr_i;
        end
    end
endmodule

/* File: rtl/accel_core.sv */
// Accelerometer control core: trim load, sample pacing, data-ready,
// wake and free-fall events, sleep-to-wakeup, Wishbone registers.
// Assumes front end and trim store run on clk_i; trim store answers
// one cycle after the address.
// Function
// (R1) Self-test force applied only while selftest_enable is set.
// (R2) Self-test output is real plus force signal, scaled by range.
// (R3) Factory gain and offset trim copied from storage after reset.
// (R4) Data-ready rises when a full new x, y, z set is stored.
// (R5) Wake and free-fall events raised on software-enabled axes.
// (R6) Wake and free-fall run together on separate interrupt outputs.
// (R7) Low-power mode keeps sampling at a slow rate with events.
// (R8) Sleep-to-wakeup leaves low-power rate on any detected event.
// (R9) Output words are two's complement, zero at zero acceleration.
// (R10) Data-ready drops after the host reads the newest set.
`timescale 1ns/1ps
module accel_core #(
    parameter int unsigned NORMAL_CYC = accel_pkg::NORMAL_ODR_CYC,
    parameter int unsigned LOW_CYC    = accel_pkg::LOW_ODR_CYC
) (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [7:0]                   wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic [31:0]                       wb_dat_o,
    output logic                              wb_ack_o,
    output logic [accel_pkg::NVM_AW-1:0]      nvm_addr_o,
    input  wire logic [accel_pkg::GAIN_W-1:0] nvm_data_i,
    output logic                              sample_req_o,
    input  wire logic                         raw_valid_i,
    input  wire logic [accel_pkg::DATA_W-1:0] raw_x_i,
    input  wire logic [accel_pkg::DATA_W-1:0] raw_y_i,
    input  wire logic [accel_pkg::DATA_W-1:0] raw_z_i,
    output logic                              selftest_force_o,
    output logic                              data_ready_o,
    output logic                              int_wake_o,
    output logic                              int_ff_o
);
    import accel_pkg::*;

    core_state_t                state_q;
    logic [NVM_AW-1:0]          load_idx_q;
    logic                       load_cap_q;
    logic [NVM_AW-1:0]          cap_idx_q;
    logic [GAIN_W-1:0]          gain_q [3];
    logic [OFFS_W-1:0]          offs_q [3];
    logic [CTRL_W-1:0]          ctrl_q;
    logic [DATA_W-1:0]          wake_thr_q;
    logic [DATA_W-1:0]          ff_thr_q;
    logic [31:0]                rate_cnt_q;
    logic                       woken_q;
    logic                       slow;
    logic                       sample_d1_q;
    logic [DATA_W-1:0]          raw [3];
    logic [DATA_W-1:0]          out [3];
    logic [2:0]                 above;
    logic [2:0]                 below;
    logic [2:0]                 wk_en;
    logic [2:0]                 ff_en;
    logic                       wake_ev;
    logic                       ff_ev;
    logic                       wb_req;
    logic                       wb_wr;
    logic                       rd_z;
    logic [31:0]                rd_data;
    logic [DATA_W-1:0]          wmerge;

    localparam logic signed [DATA_W-1:0] ST_FORCE [3] =
        '{ST_FORCE_X, ST_FORCE_Y, ST_FORCE_Z};

    ////////////////////////////////////////////////////////////////////////
    // Trim load after reset, one word per cycle

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q    <= TRIM_LOAD;
            load_idx_q <= '0;
            load_cap_q <= 1'b0;
            cap_idx_q  <= '0;
        end else begin
            load_cap_q <= 1'b0;
            cap_idx_q  <= load_idx_q;
            unique case (state_q)
                TRIM_LOAD: begin
                    if (load_idx_q == NVM_AW'(TRIM_CNT)) begin
                        state_q <= RUN;
                    end else begin
                        load_cap_q <= 1'b1;
                        load_idx_q <= load_idx_q + 1'b1;
                    end
                end
                RUN: begin
                end
            endcase
        end
    end

    assign nvm_addr_o = load_idx_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gain_q <= '{GAIN_RST, GAIN_RST, GAIN_RST};
            offs_q <= '{OFFS_RST, OFFS_RST, OFFS_RST};
        end else if (load_cap_q) begin
            if (cap_idx_q < NVM_AW'(3)) begin
                gain_q[cap_idx_q[1:0]] <= nvm_data_i;  // [R3]
            end else begin
                offs_q[2'(cap_idx_q - NVM_AW'(3))] <= nvm_data_i;  // [R3]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample pacing; slow rate only while asleep

    assign slow = ctrl_q[CTRL_LP] && !woken_q;  // [R7] [R8]

    always_ff @(posedge clk_i) begin
        if (rst_i || state_q != RUN) begin
            rate_cnt_q   <= '0;
            sample_req_o <= 1'b0;
        end else begin
            sample_req_o <= 1'b0;
            if (rate_cnt_q >= (slow ? LOW_CYC - 1 : NORMAL_CYC - 1)) begin
                rate_cnt_q   <= '0;
                sample_req_o <= 1'b1;  // [R7]
            end else begin
                rate_cnt_q <= rate_cnt_q + 1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Axis datapaths

    assign raw   = '{raw_x_i, raw_y_i, raw_z_i};
    assign wk_en = ctrl_q[CTRL_WK_LO +: 3];
    assign ff_en = ctrl_q[CTRL_FF_LO +: 3];

    for (genvar a = 0; a < 3; a++) begin : g_axis
        accel_axis #(
            .ST_FORCE (ST_FORCE[a])
        ) u_axis (
            .clk_i             (clk_i),
            .rst_i             (rst_i),
            .sample_i          (raw_valid_i && state_q == RUN),
            .raw_i             (raw[a]),
            .gain_i            (gain_q[a]),
            .offset_i          (offs_q[a]),
            .selftest_enable_i (ctrl_q[CTRL_ST]),
            .fs_i              (ctrl_q[CTRL_FS_LO +: 2]),
            .wake_thr_i        (wake_thr_q),
            .ff_thr_i          (ff_thr_q),
            .out_o             (out[a]),
            .above_o           (above[a]),
            .below_o           (below[a])
        );
    end

    // Wake: any enabled axis over; free fall: all enabled axes under
    assign wake_ev = |(above & wk_en);  // [R5]
    assign ff_ev   = (|ff_en) && ((below & ff_en) == ff_en);  // [R5]

    ////////////////////////////////////////////////////////////////////////
    // Event outputs, data-ready and wake latch

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_d1_q <= 1'b0;
        end else begin
            sample_d1_q <= raw_valid_i && state_q == RUN;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_wake_o <= 1'b0;
            int_ff_o   <= 1'b0;
        end else if (sample_d1_q) begin
            int_wake_o <= wake_ev;  // [R6]
            int_ff_o   <= ff_ev;  // [R6]
        end
    end

    // New set wins over a read clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_ready_o <= 1'b0;
        end else if (sample_d1_q) begin
            data_ready_o <= 1'b1;  // [R4]
        end else if (rd_z) begin
            data_ready_o <= 1'b0;  // [R10]
        end
    end

    // Stays awake until software writes the control word again
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            woken_q <= 1'b0;
        end else if (sample_d1_q && ctrl_q[CTRL_STW] && (wake_ev || ff_ev))
        begin
            woken_q <= 1'b1;  // [R8]
        end else if (wb_wr && wb_adr_i == ADR_CTRL) begin
            woken_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            selftest_force_o <= 1'b0;
        end else begin
            selftest_force_o <= ctrl_q[CTRL_ST];  // [R1]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave, one wait state, ack for every address

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr  = wb_req && wb_we_i;
    assign rd_z   = wb_req && !wb_we_i && wb_adr_i == ADR_OUT_Z;  // [R10]

    always_comb begin
        wmerge = '0;
        wmerge[7:0]  = wb_dat_i[7:0];
        wmerge[15:8] = wb_dat_i[15:8];
        rd_data = '0;
        unique case (wb_adr_i)
            ADR_CTRL:     rd_data[CTRL_W-1:0] = ctrl_q;
            ADR_WAKE_THR: rd_data[DATA_W-1:0] = wake_thr_q;
            ADR_FF_THR:   rd_data[DATA_W-1:0] = ff_thr_q;
            ADR_STATUS: begin
                rd_data[STS_DRDY] = data_ready_o;
                rd_data[STS_WAKE] = int_wake_o;
                rd_data[STS_FF]   = int_ff_o;
                rd_data[STS_TRIM] = state_q == RUN;
                rd_data[STS_SLOW] = slow;
            end
            ADR_OUT_X:    rd_data = {{16{out[0][DATA_W-1]}}, out[0]};
            ADR_OUT_Y:    rd_data = {{16{out[1][DATA_W-1]}}, out[1]};
            ADR_OUT_Z:    rd_data = {{16{out[2][DATA_W-1]}}, out[2]};
            default:      rd_data = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req && !wb_we_i ? rd_data : '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q     <= CTRL_RST;
            wake_thr_q <= WAKE_THR_RST;
            ff_thr_q   <= FF_THR_RST;
        end else if (wb_wr) begin
            unique case (wb_adr_i)
                ADR_CTRL: begin
                    if (wb_sel_i[0]) ctrl_q[7:0] <= wmerge[7:0];
                    if (wb_sel_i[1]) ctrl_q[CTRL_W-1:8] <= wmerge[CTRL_W-1:8];
                end
                ADR_WAKE_THR: begin
                    if (wb_sel_i[0]) wake_thr_q[7:0]  <= wmerge[7:0];
                    if (wb_sel_i[1]) wake_thr_q[15:8] <= wmerge[15:8];
                end
                ADR_FF_THR: begin
                    if (wb_sel_i[0]) ff_thr_q[7:0]  <= wmerge[7:0];
                    if (wb_sel_i[1]) ff_thr_q[15:8] <= wmerge[15:8];
                end
                default: begin
                end
            endcase
        end
    end
endmodule

/* File: rtl/accel_pkg.sv */
// Constants for the accelerometer control core: register map, field
// layout, reset values and sample-rate timing.
// Assumes a single 200 MHz clock and a 32-bit classic Wishbone bus.
package accel_pkg;

    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned NORMAL_ODR_HZ = 50;
    localparam int unsigned LOW_ODR_HZ    = 1;
    // Each period rounds down to whole cycles
    localparam int unsigned NORMAL_ODR_CYC = CLK_HZ / NORMAL_ODR_HZ;
    localparam int unsigned LOW_ODR_CYC    = CLK_HZ / LOW_ODR_HZ;

    localparam int unsigned DATA_W   = 16;
    localparam int unsigned GAIN_W   = 8;
    localparam int unsigned OFFS_W   = 8;
    localparam int unsigned GAIN_SH  = 7;  // Gain trim of 128 is unity
    localparam int unsigned NVM_AW   = 3;
    localparam int unsigned TRIM_CNT = 6;  // Gain x,y,z then offset x,y,z

    // Byte addresses of the register words
    localparam logic [7:0] ADR_CTRL     = 8'h00;
    localparam logic [7:0] ADR_WAKE_THR = 8'h04;
    localparam logic [7:0] ADR_FF_THR   = 8'h08;
    localparam logic [7:0] ADR_STATUS   = 8'h0C;
    localparam logic [7:0] ADR_OUT_X    = 8'h10;
    localparam logic [7:0] ADR_OUT_Y    = 8'h14;
    localparam logic [7:0] ADR_OUT_Z    = 8'h18;

    // accel_control_four fields
    localparam int unsigned CTRL_W     = 11;
    localparam int unsigned CTRL_ST    = 0;  // selftest_enable
    localparam int unsigned CTRL_FS_LO = 1;  // Full scale, 2 bits
    localparam int unsigned CTRL_LP    = 3;
    localparam int unsigned CTRL_STW   = 4;
    localparam int unsigned CTRL_WK_LO = 5;  // Wake axis enables x,y,z
    localparam int unsigned CTRL_FF_LO = 8;  // Free-fall axis enables
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

    localparam logic [DATA_W-1:0] WAKE_THR_RST = 16'h0400;
    localparam logic [DATA_W-1:0] FF_THR_RST   = 16'h0100;

    // Status bit positions
    localparam int unsigned STS_DRDY = 0;
    localparam int unsigned STS_WAKE = 1;
    localparam int unsigned STS_FF   = 2;
    localparam int unsigned STS_TRIM = 3;
    localparam int unsigned STS_SLOW = 4;

    // Test-force per axis in output LSb at the narrowest range
    localparam logic signed [DATA_W-1:0] ST_FORCE_X = 16'sh012C;
    localparam logic signed [DATA_W-1:0] ST_FORCE_Y = -16'sh012C;
    localparam logic signed [DATA_W-1:0] ST_FORCE_Z = 16'sh015E;

    localparam logic [GAIN_W-1:0] GAIN_RST = 8'h80;
    localparam logic [OFFS_W-1:0] OFFS_RST = 8'h00;

    typedef enum logic [0:0] {TRIM_LOAD, RUN} core_state_t;

endpackage

/* File: sim/accel_core_props.sv */
// Checker for the accelerometer core: bus answer, data-ready, wake event.
// Sees only core ports; bound to every accel_core instance.
`timescale 1ns/1ps
module accel_core_props #(
    parameter int unsigned NORMAL_CYC = 20,
    parameter int unsigned LOW_CYC    = 60
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        raw_valid_i,
    input wire logic        selftest_force_o,
    input wire logic        data_ready_o,
    input wire logic        int_wake_o
);
    import accel_pkg::*;
    logic z_rd;

    assign z_rd = wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == ADR_OUT_Z;
    default clocking cb_main @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    property p_unmapped;
        wb_ack_o && !wb_we_i && wb_adr_i > ADR_OUT_Z |-> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped data");
    property p_force;
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL
            |=> selftest_force_o == $past(wb_dat_i[CTRL_ST]);
    endproperty
    a_force: assert property (p_force) else $error("force level");
    property p_drdy_rise;
        $rose(data_ready_o) |-> $past(raw_valid_i, 2);
    endproperty
    a_drdy_rise: assert property (p_drdy_rise) else $error("drdy up");
    property p_drdy_hold;
        data_ready_o && !z_rd |=> data_ready_o;
    endproperty
    a_drdy_hold: assert property (p_drdy_hold) else $error("drdy off");
    // A set landing in the same cycle wins over the clear
    property p_drdy_clr;
        wb_ack_o && z_rd && !$past(raw_valid_i) && !$past(raw_valid_i, 2)
            |=> !data_ready_o;
    endproperty
    a_drdy_clr: assert property (p_drdy_clr) else $error("drdy kept");
    property p_wake_set;
        !$stable(int_wake_o) |-> $past(raw_valid_i, 2);
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wake moved");
endmodule

bind accel_core accel_core_props #(
    .NORMAL_CYC(NORMAL_CYC),
    .LOW_CYC(LOW_CYC)
) accel_core_props_i (.*);

/* File: sim/accel_front_model.sv */
// Behavioural front end and trim store on the far side of the core.
// Assumes the core clock; trim answers one cycle after the address.
`timescale 1ns/1ps
module accel_front_model #(
    parameter logic [47:0] TRIM = 48'h0
) (
    input  wire logic        clk_i,
    input  wire logic [2:0]  nvm_addr_i,
    output logic      [7:0]  nvm_data_o,
    input  wire logic        sample_req_i,
    input  wire logic        slow_i,
    input  wire logic [15:0] ax_i,
    input  wire logic [15:0] ay_i,
    input  wire logic [15:0] az_i,
    output logic             raw_valid_o,
    output logic      [15:0] raw_x_o,
    output logic      [15:0] raw_y_o,
    output logic      [15:0] raw_z_o
);
    logic [3:0] dly_q;

    // Unused addresses toggle so a stray read shows
    always_ff @(posedge clk_i) begin
        nvm_data_o <= (nvm_addr_i < 3'h6) ? TRIM[8*nvm_addr_i +: 8]
                                          : ~nvm_data_o;
    end
    always_ff @(posedge clk_i) begin
        dly_q <= {dly_q[2:0], sample_req_i === 1'b1};
    end
    ////////////////////////////////////////////////////////////
    // Slow mode answers three cycles later than prompt mode
    assign raw_valid_o = slow_i ? dly_q[3] : dly_q[0];
    // Inverse outside the strobe, so a stale capture cannot match
    assign raw_x_o = raw_valid_o ? ax_i : ~ax_i;
    assign raw_y_o = raw_valid_o ? ay_i : ~ay_i;
    assign raw_z_o = raw_valid_o ? az_i : ~az_i;
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the accelerometer control core.
// Assumes the front-end model answers samples and trim reads.
`timescale 1ns/1ps
module tb;
    import accel_pkg::*;
    localparam int unsigned NCYC = 20;
    localparam int unsigned LCYC = 60;
    // Gains x,y,z then signed offsets x,y,z
    localparam logic [47:0] TRIM = 48'h00FC_0240_C080;
    localparam logic [31:0] EV [3] = '{32'h0000_0420, 32'h0, 32'h0000_0180};
    logic        clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00, nvm_data_i;
    logic [3:0]  wb_sel_i = 4'h3;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic [2:0]  nvm_addr_o;
    logic [15:0] raw_x_i, raw_y_i, raw_z_i;
    logic        wb_ack_o, sample_req_o, raw_valid_i, selftest_force_o;
    logic        data_ready_o, int_wake_o, int_ff_o;
    int          n_fail = 0, cmp_count = 0, ticks = 0, g;
    int          rw [3] = '{100, -50, 0};
    int          fv [3] = '{ST_FORCE_X, ST_FORCE_Y, ST_FORCE_Z};

    always #2.5 clk_i = ~clk_i;

    accel_core #(.NORMAL_CYC(NCYC), .LOW_CYC(LCYC)) accel_core_i (.*);
    accel_front_model #(.TRIM(TRIM)) accel_front_model_i (
        .clk_i, .nvm_addr_i(nvm_addr_o), .nvm_data_o(nvm_data_i),
        .sample_req_i(sample_req_o), .slow_i(slow), .ax_i(16'(rw[0])),
        .ay_i(16'(rw[1])), .az_i(16'(rw[2])), .raw_valid_o(raw_valid_i),
        .raw_x_o(raw_x_i), .raw_y_o(raw_y_i), .raw_z_o(raw_z_i)
    );
    ////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, s);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, string n);
        acc(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask
    // Two sets, so the one checked was made under current settings
    task automatic fresh;
        repeat (2) begin
            acc(1'b0, ADR_OUT_Z, 32'h0);
            do @(negedge clk_i); while (data_ready_o !== 1'b1);
        end
    endtask
    task automatic gap;
        do @(negedge clk_i); while (sample_req_o !== 1'b1);
        g = 0;
        do begin
            g++;
            @(negedge clk_i);
        end while (sample_req_o !== 1'b1);
    endtask
    function automatic logic [31:0] f_out(int r, int k, int fs);
        int v;
        v = (r * int'(TRIM[8*k +: 8])) >>> 7;
        v = v - int'($signed(TRIM[8*k+24 +: 8]));
        return 32'(v >>> fs);
    endfunction
    task automatic rd_set(input int st, input int fs);
        for (int k = 0; k < 3; k++) begin
            rd(ADR_OUT_X + 8'(4 * k), f_out(rw[k] + st * fv[k], k, fs), "out");
        end
    endtask
    task automatic end_of_test;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        ticks <= ticks + 1;
        if (ticks == 20000) begin
            n_fail++;
            $display("[FAIL] watchdog expected finish seen hang");
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(negedge clk_i);
        chk("force", 32'h0, 32'(selftest_force_o));
        rd(ADR_CTRL, 32'(CTRL_RST), "ctrl");
        rd(ADR_WAKE_THR, 32'(WAKE_THR_RST), "wake_thr");
        rd(ADR_FF_THR, 32'(FF_THR_RST), "ff_thr");
        acc(1'b1, 8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C, 32'h0, "unmapped");
        acc(1'b0, ADR_STATUS, 32'h0);
        chk("trim", 32'h1, 32'(q[STS_TRIM]));
        fresh();
        rd_set(0, 0);
        @(negedge clk_i);
        chk("drdy", 32'h0, 32'(data_ready_o));
        slow = 1'b1;
        acc(1'b1, ADR_CTRL, 32'h3);
        repeat (2) @(negedge clk_i);
        chk("force", 32'h1, 32'(selftest_force_o));
        fresh();
        rd_set(1, 1);
        acc(1'b1, ADR_CTRL, 32'h0);
        repeat (2) @(negedge clk_i);
        chk("force", 32'h0, 32'(selftest_force_o));
        slow = 1'b0;
        rw[0] = 200;
        acc(1'b1, ADR_WAKE_THR, 32'h40);
        acc(1'b1, ADR_FF_THR, 32'h10);
        for (int k = 0; k < 3; k++) begin
            acc(1'b1, ADR_CTRL, EV[k]);
            fresh();
            chk("int_wake", 32'(k == 0), 32'(int_wake_o));
            chk("int_ff", 32'(k == 0), 32'(int_ff_o));
        end
        for (int k = 0; k < 2; k++) begin
            acc(1'b1, ADR_CTRL, (k == 1) ? 32'h38 : 32'h28);
            fresh();
            chk("lp_wake", 32'h1, 32'(int_wake_o));
            gap();
            chk("gap", (k == 1) ? NCYC : LCYC, 32'(g));
            acc(1'b0, ADR_STATUS, 32'h0);
            chk("slow", 32'(k == 0), 32'(q[STS_SLOW]));
        end
        end_of_test();
    end
endmodule
